// ==== hdl/dca_device.sv ====
// device end: samples link pins, collects and decodes the header
// assumes link pins asynchronous to core_clk_i, at most a quarter rate
`timescale 1ns/1ps
`default_nettype none
`include "dca_defs.svh"
module dca_device
    import dca_pkg::*;
(
    input  wire logic  core_clk_i,
    input  wire logic  srst_i,
    dca_link_if.device link,
    output logic       hdr_valid_o,
    output logic       is_read_o,
    output logic       is_reg_o,
    output logic       is_linear_o,
    output logic [13:0] row_o,
    output logic [5:0] ucol_o,
    output logic [2:0] lcol_o,
    output logic [22:0] word_addr_o,
    output logic       access_start_o,
    output logic       page_cross_o
);
    // ***********************************
    // pin synchronisers
    // ***********************************
    logic [1:0] cs_s_r, ck_s_r, rs_s_r;
    logic [7:0] dq_a_r, dq_b_r;
    logic       ck_d_r;
    always_ff @(posedge core_clk_i) begin
        cs_s_r <= {cs_s_r[0], link.cs_n};
        ck_s_r <= {ck_s_r[0], link.clk};
        rs_s_r <= {rs_s_r[0], link.rst_n};
        dq_a_r <= link.dq;
        dq_b_r <= dq_a_r;
        ck_d_r <= ck_s_r[1];
    end
    wire logic rst   = srst_i | ~rs_s_r[1];
    wire logic edg   = ck_s_r[1] ^ ck_d_r;            // R18
    // ***********************************
    // header capture
    // ***********************************
    dca_state_type state_r;
    logic [2:0]    cnt_r;
    logic [47:0]   hdr_r;
    always_ff @(posedge core_clk_i) begin
        if (rst || cs_s_r[1]) begin
            state_r <= DCA_IDLE;
            cnt_r   <= 3'h0;
        end else begin
            case (state_r)
                DCA_IDLE: begin
                    state_r <= DCA_HDR;                 // R2 R17
                end
                DCA_HDR: begin
                    if (edg) begin
                        hdr_r <= {hdr_r[39:0], dq_b_r}; // R1 R18
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == `DCA_NBYTES - 3'h1) begin
                            state_r <= DCA_DATA;        // R2
                        end
                    end
                end
                DCA_DATA: state_r <= DCA_DATA;
                default:  state_r <= DCA_IDLE;
            endcase
        end
    end
    // ***********************************
    // decode and outputs
    // ***********************************
    logic hdr_done_r;
    always_ff @(posedge core_clk_i) begin
        hdr_done_r <= (state_r == DCA_HDR) && edg &&
                      (cnt_r == `DCA_NBYTES - 3'h1) && !rst && !cs_s_r[1];
    end
    always_ff @(posedge core_clk_i) begin
        if (rst || cs_s_r[1]) begin
            hdr_valid_o    <= 1'b0;
            access_start_o <= 1'b0;
        end else begin
            // R15 upper column arrives with the fourth byte
            access_start_o <= (state_r == DCA_HDR) && edg &&
                              (cnt_r == `DCA_UCOL_BYTE);
            if (hdr_done_r) begin
                hdr_valid_o <= 1'b1;                    // R20
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            is_read_o   <= 1'b0;
            is_reg_o    <= 1'b0;
            is_linear_o <= 1'b0;
            row_o       <= 14'h0;
            ucol_o      <= 6'h0;
            lcol_o      <= 3'h0;
            word_addr_o <= 23'h0;
            page_cross_o <= 1'b0;
        end else if (hdr_done_r) begin
            is_read_o   <= hdr_r[`DCA_BIT_DIR];         // R4
            is_reg_o    <= hdr_r[`DCA_BIT_SPACE];       // R5
            is_linear_o <= hdr_r[`DCA_BIT_BURST];       // R6
            row_o       <= hdr_r[`DCA_ROW_HI:`DCA_ROW_LO];    // R9 R14
            ucol_o      <= hdr_r[`DCA_UCOL_HI:`DCA_UCOL_LO];  // R10 R12
            lcol_o      <= hdr_r[`DCA_LCOL_HI:`DCA_LCOL_LO];  // R11 R12
            // R19 address counts 16-bit words
            word_addr_o <= {hdr_r[`DCA_ROW_HI:`DCA_ROW_LO],
                            hdr_r[`DCA_UCOL_HI:`DCA_UCOL_LO],
                            hdr_r[`DCA_LCOL_HI:`DCA_LCOL_LO]};
            // R13 R16 linear burst runs into the next half-page/page
            page_cross_o <= hdr_r[`DCA_BIT_BURST];
        end
    end
    // ***********************************
    // strobe: latency flag during header, no extra latency
    // ***********************************
    logic s_oe_r;
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            s_oe_r <= 1'b0;
        end else begin
            s_oe_r <= (state_r == DCA_HDR);
        end
    end
    assign link.strobe_s_oe = s_oe_r;
    assign link.strobe_s2m  = 1'b0;
    assign link.dq_s_oe     = 1'b0;
    assign link.dq_s2m      = 8'h00;
endmodule
`default_nettype wire

// ==== hdl/dca_master.sv ====
// master end: AHB-Lite slave registers, sends one header per order
// assumes single word AHB transfers, zero wait states
`timescale 1ns/1ps
`default_nettype none
`include "dca_defs.svh"
module dca_master
    import dca_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    dca_link_if.master       link
);
    logic [15:0] hdr_hi_r;
    logic [31:0] hdr_lo_r;
    logic        go_r, busy_r, wr_ph_r;
    logic [31:0] a_r;
    dca_state_type state_r;
    logic [3:0]  div_r;
    logic [2:0]  cnt_r;
    logic [47:0] sh_r;
    logic        ck_r, cs_r;
    logic        cc_r, oe_r, rstn_r;
    // ***********************************
    // bus slave
    // ***********************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ph_r <= 1'b0;
            a_r     <= 32'h0;
            hdr_hi_r <= 16'h0;
            hdr_lo_r <= 32'h0;
            go_r    <= 1'b0;
            hrdata_o <= 32'h0;
        end else begin
            go_r <= 1'b0;
            wr_ph_r <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
            if (hsel_i && hready_i && htrans_i[1]) begin
                a_r <= haddr_i;
                case (haddr_i)
                    `DCA_REG_HDR_HI: hrdata_o <= {16'h0, hdr_hi_r};
                    `DCA_REG_HDR_LO: hrdata_o <= hdr_lo_r;
                    `DCA_REG_STATUS: hrdata_o <= {31'h0, busy_r | go_r};
                    default:         hrdata_o <= 32'h0;
                endcase
            end
            if (wr_ph_r) begin
                case (a_r)
                    // R7 R8 reserved header bits are cleared
                    `DCA_REG_HDR_HI: hdr_hi_r <= {hwdata_i[15:13], 9'h0,
                                                  hwdata_i[3:0]};
                    `DCA_REG_HDR_LO: hdr_lo_r <= {hwdata_i[31:16], 13'h0,
                                                  hwdata_i[2:0]};
                    `DCA_REG_CTRL:   go_r <= hwdata_i[0] & ~busy_r;
                    default: ;
                endcase
            end
        end
    end
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    // ***********************************
    // link sequencer
    // ***********************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_r <= DCA_IDLE;
            busy_r  <= 1'b0;
            cs_r    <= 1'b1;
            ck_r    <= 1'b0;
            cc_r    <= 1'b1;
            oe_r    <= 1'b0;
            div_r   <= 4'h0;
            cnt_r   <= 3'h0;
            sh_r    <= 48'h0;
        end else begin
            case (state_r)
                DCA_IDLE: begin
                    if (go_r) begin
                        busy_r  <= 1'b1;
                        cs_r    <= 1'b0;                // R17
                        oe_r    <= 1'b1;
                        sh_r    <= {hdr_hi_r, hdr_lo_r};
                        div_r   <= 4'h0;
                        cnt_r   <= 3'h0;
                        state_r <= DCA_HDR;
                    end
                end
                DCA_HDR: begin
                    div_r <= div_r + 4'h1;
                    // R3 data changes mid half period, centred on edge
                    if (div_r == `DCA_HALF_DIV) begin
                        div_r <= 4'h0;
                        ck_r  <= ~ck_r;                 // R18
                        cc_r  <= ~cc_r;
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == `DCA_NBYTES - 3'h1) begin
                            state_r <= DCA_END;         // R2
                        end
                    end else if (div_r == `DCA_SHIFT_DIV &&
                                 cnt_r != 3'h0) begin
                        sh_r <= {sh_r[39:0], 8'h00};    // R1
                    end
                end
                DCA_END: begin
                    div_r <= div_r + 4'h1;
                    if (div_r == `DCA_HALF_DIV) begin
                        cs_r    <= 1'b1;
                        oe_r    <= 1'b0;
                        busy_r  <= 1'b0;
                        state_r <= DCA_IDLE;
                    end
                end
                default: state_r <= DCA_IDLE;
            endcase
        end
    end
    assign link.cs_n             = cs_r;
    assign link.clk              = ck_r;
    // link reset follows the core reset, registered
    always_ff @(posedge core_clk_i) begin
        rstn_r <= ~srst_i;
    end
    assign link.clock_complement = cc_r;
    assign link.rst_n            = rstn_r;
    assign link.dq_m2s           = sh_r[47:40];
    assign link.dq_m_oe          = oe_r;
endmodule
`default_nettype wire

// ==== inc/dca_defs.svh ====
// constants for the command/address header decoder and its master
// assumes inclusion by bare name from package and modules
// Notes on behaviour
// R1: six header bytes, most significant first
// R2: transaction starts with three header cycles
// R3: master centres bytes on sampling edges
// R4: header bit 47 high means read
// R5: header bit 46 high means register space
// R6: header bit 45 high means linear burst
// R7: master sends bits 44 to 36 zero
// R8: master sends bits 15 to 3 zero
// R9: bits 35 to 22 form row address
// R10: bits 21 to 16 form upper column
// R11: bits 2 to 0 give start word
// R12: half-page of eight words, word within
// R13: sixteen word pages, strobe latency at crossing; the device holds strobe_s2m low and never adds it
// R14: row crossing may add strobe latency
// R15: read access timing starts after upper column
// R16: linear reads interleave successive half-pages
// R17: select falls while clock idles low
// R18: one header byte per clock edge
// R19: each address names one 16-bit word
// R20: decoded fields appear edge after sixth byte
`ifndef DCA_DEFS_SVH
`define DCA_DEFS_SVH
`define DCA_BIT_DIR      47
`define DCA_BIT_SPACE    46
`define DCA_BIT_BURST    45
`define DCA_ROW_HI       35
`define DCA_ROW_LO       22
`define DCA_UCOL_HI      21
`define DCA_UCOL_LO      16
`define DCA_LCOL_HI      2
`define DCA_LCOL_LO      0
`define DCA_NBYTES       3'h6
`define DCA_HALF_DIV     4'h5
`define DCA_SHIFT_DIV    4'h2
`define DCA_UCOL_BYTE    3'h3
`define DCA_REG_CTRL     32'h0000_0000
`define DCA_REG_HDR_HI   32'h0000_0004
`define DCA_REG_HDR_LO   32'h0000_0008
`define DCA_REG_STATUS   32'h0000_000C
`endif

// ==== inc/dca_link_if.sv ====
// link wires between the master and the decoding device
// assumes the bench resolves dq and strobe from the enables
`timescale 1ns/1ps
`default_nettype none
interface dca_link_if;
    logic       cs_n;
    logic       clk;
    logic       clock_complement;
    logic       rst_n;
    logic [7:0] dq_m2s;
    logic       dq_m_oe;
    logic [7:0] dq_s2m;
    logic       dq_s_oe;
    logic [7:0] dq;
    logic       strobe_s2m;
    logic       strobe_s_oe;
    logic       rw_data_strobe;
    modport master (output cs_n, clk, clock_complement, rst_n, dq_m2s,
                    dq_m_oe, input dq, rw_data_strobe);
    modport device (input cs_n, clk, rst_n, dq, output dq_s2m, dq_s_oe,
                    strobe_s2m, strobe_s_oe);
endinterface
`default_nettype wire

// ==== inc/dca_pkg.sv ====
// types shared by both ends of the header link
// assumes dca_defs.svh on the include path
`include "dca_defs.svh"
package dca_pkg;
    typedef enum logic [1:0] {
        DCA_IDLE = 2'h0,
        DCA_HDR  = 2'h1,
        DCA_DATA = 2'h3,
        DCA_END  = 2'h2
    } dca_state_type;
endpackage

// ==== sim/dca_props.sv ====
// checker for the header link between master and device
// assumes link signals sampled on the master core clock
`timescale 1ns/1ps
`default_nettype none
module dca_props (
    input wire logic       core_clk_i,
    input wire logic       srst_i,
    input wire logic       cs_n,
    input wire logic       clk,
    input wire logic       clock_complement,
    input wire logic [7:0] dq_m2s,
    input wire logic       dq_m_oe,
    input wire logic       strobe_s2m,
    input wire logic       strobe_s_oe
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // ****************************************
    // link clock edge counter
    // ****************************************
    logic       clk_q;
    logic [2:0] edges_r;
    always_ff @(posedge core_clk_i) begin
        clk_q <= clk;
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i || cs_n) begin
            edges_r <= 3'h0;
        end else if (clk != clk_q) begin
            edges_r <= edges_r + 3'h1;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    property p_six;   $rose(cs_n) |-> edges_r == 3'h6; endproperty
    property p_idle;  edges_r == 3'h6 |-> !clk; endproperty
    property p_hold;  (clk != clk_q) |=> $stable(clk) [*5]; endproperty
    property p_center;
        (clk != clk_q) && !cs_n |-> dq_m2s == $past(dq_m2s, 2);
    endproperty
    property p_first; $fell(cs_n) |-> !clk; endproperty
    property p_cc;    clock_complement == !clk; endproperty
    property p_oe;    dq_m_oe == !cs_n; endproperty
    property p_strobe; !cs_n && strobe_s_oe |-> !strobe_s2m; endproperty
    a_six:    assert property (p_six) else $error("edge count wrong");
    a_idle:   assert property (p_idle) else $error("clock not idle");
    a_hold:   assert property (p_hold) else $error("clock half short");
    a_center: assert property (p_center) else $error("byte moved");
    a_first:  assert property (p_first) else $error("select high clk");
    a_cc:     assert property (p_cc) else $error("complement wrong");
    a_oe:     assert property (p_oe) else $error("enable wrong");
    a_strobe: assert property (p_strobe) else $error("latency seen");
    c_start: cover property ($fell(cs_n));
    c_end:   cover property ($rose(cs_n));
    c_six:   cover property (edges_r == 3'h6);
endmodule
`default_nettype wire

// ==== sim/ddr_cmd_addr_decoder_test.sv ====
// self-checking bench: AHB master to dca_master, link to dca_device
// assumes design files and inc/ on the compile path
`timescale 1ns/1ps
`default_nettype none
`include "dca_defs.svh"
module ddr_cmd_addr_decoder_test;
    import dca_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hdr_valid, is_read, is_reg, is_linear, access_start, pcross;
    logic [13:0] row;
    logic [5:0]  ucol;
    logic [2:0]  lcol;
    logic [22:0] waddr;
    logic [7:0]  cyc = 8'h0;
    logic        clk_q = 1'b0, cs_q = 1'b1, hv_q = 1'b0;
    logic [47:0] wire_sr = 48'h0, hm;
    int          frames = 0, starts = 0, valids = 0, f0, s0, v0;
    int          fail_count = 0, num_checks = 0;
    localparam logic [47:0] MASK = 48'hE00F_FFFF_0007;
    logic [47:0] rows [4] = '{48'h8000_0000_0000, 48'h6003_FFFF_0007,
                              48'hBFF2_4081_FFFA, 48'hC001_5555_0003};
    dca_link_if link();
    dca_master dca_master_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .link(link));
    dca_device dca_device_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .link(link), .hdr_valid_o(hdr_valid), .is_read_o(is_read),
        .is_reg_o(is_reg), .is_linear_o(is_linear), .row_o(row),
        .ucol_o(ucol), .lcol_o(lcol), .word_addr_o(waddr),
        .access_start_o(access_start), .page_cross_o(pcross));
    dca_props dca_props_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .cs_n(link.cs_n), .clk(link.clk),
        .clock_complement(link.clock_complement), .dq_m2s(link.dq_m2s),
        .dq_m_oe(link.dq_m_oe), .strobe_s2m(link.strobe_s2m),
        .strobe_s_oe(link.strobe_s_oe));
    // ****************************************
    // clock, wires and link monitor
    // ****************************************
    always #5 core_clk_i = ~core_clk_i;
    assign link.dq = link.dq_m_oe ? link.dq_m2s :
                     (link.dq_s_oe ? link.dq_s2m : cyc);
    assign link.rw_data_strobe = link.strobe_s_oe ? link.strobe_s2m : cyc[0];
    always @(posedge core_clk_i) begin
        cyc <= cyc + 8'h1;
        clk_q <= link.clk;
        cs_q <= link.cs_n;
        hv_q <= hdr_valid;
        if (link.cs_n === 1'b0 && link.clk !== clk_q) begin
            wire_sr <= {wire_sr[39:0], link.dq};
        end
        if (cs_q === 1'b1 && link.cs_n === 1'b0) frames <= frames + 1;
        if (access_start === 1'b1) starts <= starts + 1;
        if (hdr_valid === 1'b1 && hv_q !== 1'b1) valids <= valids + 1;
    end
    // ****************************************
    // tasks
    // ****************************************
    task chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task send(input logic [47:0] h);
        ahb(1'b1, `DCA_REG_HDR_HI, {16'h0, h[47:32]});
        ahb(1'b1, `DCA_REG_HDR_LO, h[31:0]);
        ahb(1'b1, `DCA_REG_CTRL, 32'h1);
    endtask
    task wait_idle();
        for (int n = 0; n < 300; n++) begin
            ahb(1'b0, `DCA_REG_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        chk(48'(rd[0]), 48'h0);
        repeat (6) @(posedge core_clk_i);
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        chk(48'(hdr_valid), 48'h0);
        chk(48'(link.cs_n), 48'h1);
        for (int i = 0; i < 4; i++) begin
            hm = rows[i] & MASK;
            f0 = frames;
            s0 = starts;
            v0 = valids;
            send(rows[i]);
            wait_idle();
            chk(wire_sr, hm);
            chk(48'(is_read), 48'(hm[47]));
            chk(48'(is_reg), 48'(hm[46]));
            chk(48'(is_linear), 48'(hm[45]));
            chk(48'(row), 48'(hm[35:22]));
            chk(48'(ucol), 48'(hm[21:16]));
            chk(48'(lcol), 48'(hm[2:0]));
            chk(48'(waddr), 48'({hm[35:16], hm[2:0]}));
            chk(48'(pcross), 48'(hm[45]));
            chk(48'(starts - s0), 48'h1);
            chk(48'(valids - v0), 48'h1);
            chk(48'(frames - f0), 48'h1);
            chk(48'(hresp), 48'h0);
        end
        ahb(1'b0, 32'h0000_0010, 32'h0);
        chk(48'(rd), 48'h0);
        f0 = frames;
        send(rows[1]);
        ahb(1'b1, `DCA_REG_CTRL, 32'h1);
        ahb(1'b0, `DCA_REG_STATUS, 32'h0);
        chk(48'(rd[0]), 48'h1);
        wait_idle();
        chk(48'(frames - f0), 48'h1);
        chk(wire_sr, rows[1] & MASK);
        // reset in the middle of a header cuts the frame
        send(rows[2]);
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        chk(48'(link.cs_n), 48'h1);
        chk(48'(link.clk), 48'h0);
        chk(48'(hdr_valid), 48'h0);
        f0 = frames;
        v0 = valids;
        send(rows[3]);
        wait_idle();
        chk(48'(frames - f0), 48'h1);
        chk(48'(valids - v0), 48'h1);
        chk(wire_sr, rows[3] & MASK);
        chk(48'(waddr), 48'({rows[3][35:16], rows[3][2:0]}));
        end_sim();
    end
endmodule
`default_nettype wire
